// ### logic/wadr_regulator.sv
`timescale 1ns/10ps
`include "wadr_defines.svh"

module wadr_regulator #(
  parameter int unsigned BLANK_CYCLES = `WADR_BLANK_CYCLES,
  parameter int unsigned OFF_CYCLES = `WADR_OFF_CYCLES
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Step sequencing
  input wire logic i_step,
  input wire logic i_dir,
  input wire logic i_half_step,
  // Current comparator, asynchronous
  input wire logic i_above_target,
  // Outputs to the bridge and the target current DAC
  output wadr_pkg::wadr_bridge_type o_bridge,
  output logic [`WADR_DAC_W-1:0] o_target,
  output logic o_polarity
);

  // Whole state of the module
  typedef struct packed {
    logic [2:0] sync;
    logic above;
    wadr_pkg::wadr_phase_type phase;
    logic [`WADR_TIMER_W-1:0] timer;
    logic [2:0] seg;
    logic [`WADR_DAC_W-1:0] target;
    logic polarity;
    wadr_pkg::wadr_bridge_type bridge;
  } wadr_state_type;

  wadr_state_type state_q;
  wadr_state_type state_d;

  // Magnitude table of the eight half-step segments
  function automatic logic [`WADR_DAC_W-1:0] seg_level(input logic [2:0] seg);
    case (seg[1:0])
      2'h0: seg_level = 8'hb5;
      2'h1: seg_level = 8'hff;
      2'h2: seg_level = 8'hb5;
      default: seg_level = 8'h00;
    endcase
  endfunction : seg_level

  localparam logic [`WADR_TIMER_W-1:0] BLANK_LAST = `WADR_TIMER_W'(BLANK_CYCLES - 1);
  localparam logic [`WADR_TIMER_W-1:0] OFF_LAST = `WADR_TIMER_W'(OFF_CYCLES - 1);

  // Next state
  always_comb begin
    state_d = state_q;
    // Three stages; a change counts once the second and third agree
    state_d.sync = {state_q.sync[1:0], i_above_target};
    if (state_q.sync[2] == state_q.sync[1]) begin
      state_d.above = state_q.sync[2];
    end
    // Segment advance: full step moves two segments, half step one
    if (i_step) begin
      if (i_dir) begin
        state_d.seg = state_q.seg + (i_half_step ? 3'h1 : 3'h2);
      end else begin
        state_d.seg = state_q.seg - (i_half_step ? 3'h1 : 3'h2);
      end
    end
    state_d.target = seg_level(state_q.seg);
    state_d.polarity = state_q.seg[2];
    // Timer saturates so that a long drive never falls back into blanking
    if (state_q.timer != '1) begin
      state_d.timer = state_q.timer + `WADR_TIMER_W'(1);
    end
    case (state_q.phase)
      wadr_pkg::WADR_DRIVE: begin
        // Comparator ignored until blanking ends
        if (state_q.timer >= BLANK_LAST) begin
          if (state_q.above) begin
            if (state_q.timer == BLANK_LAST) begin
              state_d.phase = wadr_pkg::WADR_FAST;
            end else begin
              state_d.phase = wadr_pkg::WADR_SLOW;
            end
            state_d.timer = '0;
          end
        end
      end
      wadr_pkg::WADR_SLOW: begin
        if (state_q.timer >= OFF_LAST) begin
          state_d.timer = '0;
          if (state_q.above) begin
            state_d.phase = wadr_pkg::WADR_FAST;
          end else begin
            state_d.phase = wadr_pkg::WADR_DRIVE;
          end
        end
      end
      wadr_pkg::WADR_FAST: begin
        // Fast decay lasts only until the current reaches target
        if (!state_q.above) begin
          state_d.phase = wadr_pkg::WADR_SLOW;
          state_d.timer = '0;
        end
      end
      default: begin
        state_d.phase = wadr_pkg::WADR_DRIVE;
        state_d.timer = '0;
      end
    endcase
    // Bridge command follows the next phase; decay choice goes out on slow_decay and fast_decay
    state_d.bridge.drive = (state_d.phase == wadr_pkg::WADR_DRIVE);
    state_d.bridge.slow_decay = (state_d.phase == wadr_pkg::WADR_SLOW);
    state_d.bridge.fast_decay = (state_d.phase == wadr_pkg::WADR_FAST);
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_q <= '{sync: 3'h0, above: 1'b0, phase: wadr_pkg::WADR_IDLE, timer: '0, seg: 3'h0,
                   target: 8'h00, polarity: 1'b0, bridge: '0};
    end else begin
      state_q <= state_d;
    end
  end

  assign o_bridge = state_q.bridge;
  assign o_target = state_q.target;
  assign o_polarity = state_q.polarity;

  // Checks
  sequence s_fast_start;
    state_q.phase == wadr_pkg::WADR_FAST;
  endsequence

  sequence s_slow_restart;
    state_q.phase == wadr_pkg::WADR_SLOW && state_q.timer == '0;
  endsequence

  sequence s_cycle_start;
    state_q.phase == wadr_pkg::WADR_DRIVE && state_q.timer == '0;
  endsequence

  chk_blank_drive: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q.phase == wadr_pkg::WADR_DRIVE && state_q.timer < BLANK_LAST) |=> state_q.phase == wadr_pkg::WADR_DRIVE)
    else $error("drive left during blanking");

  chk_blank_ignore: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q.phase == wadr_pkg::WADR_DRIVE && state_q.timer < BLANK_LAST && state_q.above) |=> !o_bridge.fast_decay)
    else $error("comparator acted on during blanking");

  chk_drive_to_slow: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q.phase == wadr_pkg::WADR_DRIVE && state_q.timer > BLANK_LAST && state_q.above) |=> s_slow_restart)
    else $error("drive did not end in slow decay");

  chk_off_to_fast: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q.phase == wadr_pkg::WADR_SLOW && state_q.timer == OFF_LAST && state_q.above) |=> s_fast_start)
    else $error("fast decay not entered after off time");

  chk_fast_exit: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (s_fast_start and !state_q.above) |=> s_slow_restart ##1 state_q.timer == 16'h0001)
    else $error("fast decay did not return to fresh slow decay");

  chk_fast_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (s_fast_start and state_q.above) |=> s_fast_start)
    else $error("fast decay left while current high");

  chk_blank_fast: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q.phase == wadr_pkg::WADR_DRIVE && state_q.timer == BLANK_LAST && state_q.above) |=> s_fast_start)
    else $error("no fast decay after blanking with current high");

  chk_target_follow: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $changed(state_q.seg) |=> o_target == seg_level($past(state_q.seg)))
    else $error("target did not follow segment");

  chk_sync_filter: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $changed(state_q.above) |-> $past(state_q.sync[2]) == $past(state_q.sync[1]))
    else $error("comparator change accepted without agreement");

  chk_one_phase: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $countones({o_bridge.drive, o_bridge.slow_decay, o_bridge.fast_decay}) <= 1)
    else $error("more than one bridge phase");

  // Target and sign follow the segment
  chk_target_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q.phase != wadr_pkg::WADR_IDLE && $stable(state_q.seg)) |=> $stable(o_target))
    else $error("target moved without a segment change");

  chk_polarity_follow: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $changed(state_q.seg) |=> o_polarity == $past(state_q.seg[2]))
    else $error("sign did not follow segment");

  // Phase timing and comparator level take-over
  chk_cycle_start: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q.phase == wadr_pkg::WADR_SLOW && state_q.timer == OFF_LAST && !state_q.above) |=> s_cycle_start)
    else $error("new cycle did not start in drive");

  chk_slow_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q.phase == wadr_pkg::WADR_SLOW && state_q.timer < OFF_LAST) |=> state_q.phase == wadr_pkg::WADR_SLOW)
    else $error("slow decay left before off time");

  chk_drive_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q.phase == wadr_pkg::WADR_DRIVE && state_q.timer >= BLANK_LAST && !state_q.above) |=> o_bridge.drive)
    else $error("drive ended below target");

  chk_sync_take: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state_q.sync[2] == state_q.sync[1]) |=> state_q.above == $past(state_q.sync[2]))
    else $error("agreed comparator level not taken");

  // Segment stepping
  chk_half_fwd: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_step && i_dir && i_half_step) |=> state_q.seg == 3'($past(state_q.seg) + 3'h1))
    else $error("half step forward wrong");

  chk_full_fwd: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_step && i_dir && !i_half_step) |=> state_q.seg == 3'($past(state_q.seg) + 3'h2))
    else $error("full step forward wrong");

  chk_half_back: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_step && !i_dir && i_half_step) |=> state_q.seg == 3'($past(state_q.seg) - 3'h1))
    else $error("half step back wrong");

endmodule : wadr_regulator

// ### logic/wadr_defines.svh
`ifndef WADR_DEFINES_SVH
`define WADR_DEFINES_SVH

// Timing figures in nanoseconds and the clock period they are counted in
`define WADR_CLK_PERIOD_NS 40
`define WADR_BLANK_TIME_NS 2000
`define WADR_OFF_TIME_NS 20000
// Least times round up to whole cycles
`define WADR_BLANK_CYCLES ((`WADR_BLANK_TIME_NS + `WADR_CLK_PERIOD_NS - 1) / `WADR_CLK_PERIOD_NS)
`define WADR_OFF_CYCLES ((`WADR_OFF_TIME_NS + `WADR_CLK_PERIOD_NS - 1) / `WADR_CLK_PERIOD_NS)
// Step sequencer: eight segments per electrical turn at half step
`define WADR_SEG_COUNT 8
`define WADR_TIMER_W 16
`define WADR_DAC_W 8

`endif

// ### logic/wadr_pkg.sv
package wadr_pkg;

  // Bridge phase states, one-hot
  typedef enum logic [3:0] {
    WADR_DRIVE = 4'h1,
    WADR_SLOW  = 4'h2,
    WADR_FAST  = 4'h4,
    WADR_IDLE  = 4'h8
  } wadr_phase_type;

  // Bridge command to the power stage
  typedef struct packed {
    logic drive;
    logic slow_decay;
    logic fast_decay;
  } wadr_bridge_type;

endpackage : wadr_pkg

// ### verif/wadr_bridge_model.sv
`timescale 1ns/10ps
// Winding and comparator stand-in: current follows the bridge command
module wadr_bridge_model (
  // Bench controls
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rise,
  input wire logic [7:0] i_slow_drop,
  // Regulator side
  input wire wadr_pkg::wadr_bridge_type i_bridge,
  input wire logic [7:0] i_target,
  output logic o_above
);
  int cur_q = 0;
  // Drive raises, slow decay bleeds, fast decay pulls hard
  always @(posedge i_clk_sys) begin
    if (i_bridge.drive) cur_q <= cur_q + i_rise;
    else if (i_bridge.slow_decay) cur_q <= (cur_q > i_slow_drop) ? cur_q - i_slow_drop : 0;
    else if (i_bridge.fast_decay) cur_q <= (cur_q > 40) ? cur_q - 40 : 0;
  end
  // Analog comparator settles away from the edge
  always @(posedge i_clk_sys) o_above <= #7 (cur_q > i_target);
endmodule : wadr_bridge_model

// ### verif/test_winding_auto_decay_regulator.sv
`timescale 1ns/10ps
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %0t %s", $time, m); end end
module test_winding_auto_decay_regulator;
  localparam int BLANK = 8;
  localparam int OFF = 20;
  logic i_clk_sys = 0;
  logic i_reset = 1;
  logic i_step = 0;
  logic i_dir = 1;
  logic i_half_step = 1;
  logic i_above_target;
  logic [7:0] rise = 0;
  logic [7:0] slow_drop = 0;
  wadr_pkg::wadr_bridge_type o_bridge;
  logic [7:0] o_target;
  logic o_polarity;
  int bad_count = 0;
  int checks_done = 0;
  int n;
  logic p;
  // 25 MHz clock
  initial begin
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  wadr_regulator #(.BLANK_CYCLES(BLANK), .OFF_CYCLES(OFF)) wadr_regulator_i (.i_clk_sys(i_clk_sys),
    .i_reset(i_reset), .i_step(i_step), .i_dir(i_dir), .i_half_step(i_half_step),
    .i_above_target(i_above_target), .o_bridge(o_bridge), .o_target(o_target), .o_polarity(o_polarity));
  wadr_bridge_model wadr_bridge_model_i (.i_clk_sys(i_clk_sys), .i_rise(rise), .i_slow_drop(slow_drop),
    .i_bridge(o_bridge), .i_target(o_target), .o_above(i_above_target));
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // Cycles until the bridge command changes, bounded
  task automatic run_len(output int k);
    wadr_pkg::wadr_bridge_type b;
    b = o_bridge;
    k = 0;
    while (o_bridge === b && k < 2000) begin
      @(negedge i_clk_sys);
      k++;
    end
    if (k >= 2000) begin
      bad_count++;
      stop_test();
    end
  endtask : run_len
  task automatic step_once(input logic half, input logic dir);
    i_half_step = half;
    i_dir = dir;
    i_step = 1;
    @(negedge i_clk_sys);
    i_step = 0;
    repeat (3) @(negedge i_clk_sys);
  endtask : step_once
  task automatic t_reset();
    repeat (3) @(negedge i_clk_sys);
    `CHK(o_bridge, 3'h0, "bridge active in reset")
    i_reset = 0;
    @(negedge i_clk_sys);
    `CHK(o_bridge.drive, 1'b1, "no drive after reset")
    $display("t_reset done");
  endtask : t_reset
  task automatic t_step();
    step_once(1'b1, 1'b1);
    `CHK(o_target, 8'hff, "half step to peak")
    `CHK(o_polarity, 1'b0, "sign of first segments")
    p = o_polarity;
    step_once(1'b1, 1'b1);
    `CHK(o_target, 8'hb5, "half step forward")
    step_once(1'b1, 1'b1);
    `CHK(o_target, 8'h00, "half step to zero")
    step_once(1'b0, 1'b1);
    `CHK({o_polarity, o_target}, {~p, 8'hff}, "full step")
    step_once(1'b1, 1'b0);
    `CHK(o_target, 8'hb5, "half step back")
    $display("t_step done");
  endtask : t_step
  task automatic t_slow();
    rise = 8'h04;
    run_len(n);
    `CHK(o_bridge.slow_decay, 1'b1, "no slow after drive")
    run_len(n);
    `CHK(n, OFF, "off time length")
    `CHK(o_bridge.fast_decay, 1'b1, "no fast at off end")
    run_len(n);
    `CHK(o_bridge.slow_decay, 1'b1, "no slow after fast")
    run_len(n);
    `CHK(n, OFF, "off time not restarted")
    `CHK(o_bridge.drive, 1'b1, "no new drive cycle")
    rise = 8'h00;
    $display("t_slow done");
  endtask : t_slow
  task automatic t_blank();
    rise = 8'hc8;
    i_reset = 1;
    repeat (2) @(negedge i_clk_sys);
    i_reset = 0;
    @(negedge i_clk_sys);
    run_len(n);
    `CHK(n, BLANK, "blanking length")
    `CHK(o_bridge.fast_decay, 1'b1, "no fast after blanking")
    rise = 8'h00;
    $display("t_blank done");
  endtask : t_blank
  initial begin
    t_reset();
    t_step();
    t_slow();
    t_blank();
    stop_test();
  end
endmodule : test_winding_auto_decay_regulator
